// file: verilog/pnfc_pkg.sv
// Package of constants and types for the parallel flash host controller.
package pnfc_pkg;
   localparam int ADDR_W      = 22;
   localparam int DATA_W      = 16;
   localparam int WORDS_BIG   = 4194304;
   localparam int WORDS_SMALL = 2097152;
   localparam int PAGE_WORDS  = 8;
   localparam int WBUF_WORDS  = 16;
   // Bus timing in ns and in 40 ns clock cycles.
   localparam int CLK_NS        = 40;
   localparam int T_ACC_NS      = 90;
   localparam int T_PAGE_NS     = 25;
   localparam int ACC_CYC       = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int PAGE_CYC_RAW  = (T_PAGE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PAGE_CYC      = (PAGE_CYC_RAW < 1) ? 1 : PAGE_CYC_RAW;
   localparam int WR_CYC        = 2;
   localparam logic [3:0] CNT_ACC  = 4'(ACC_CYC);
   localparam logic [3:0] CNT_PAGE = 4'(PAGE_CYC);
   localparam logic [3:0] CNT_WR   = 4'(WR_CYC);
   // Command sequence words; the codes are plain defaults.
   localparam logic [ADDR_W-1:0] UNLOCK_A1 = 22'h000555;
   localparam logic [ADDR_W-1:0] UNLOCK_A2 = 22'h0002AA;
   localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00AA;
   localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_PROG  = 16'h00A0;
   localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
   localparam int POLL_BIT   = 7;
   localparam int TOGGLE_BIT = 6;

   typedef enum logic [1:0] {
      PNFC_OP_READ  = 2'h0,
      PNFC_OP_PROG  = 2'h1,
      PNFC_OP_ABORT = 2'h2
   } pnfc_op_t;

   typedef struct packed {
      pnfc_op_t            op;
      logic                bypass;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
   } pnfc_req_t;

   typedef struct packed {
      logic                ce_n;
      logic                oe_n;
      logic                we_n;
      logic                dq_oe;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   dq;
   } pnfc_bus_t;
endpackage : pnfc_pkg

// file: verilog/pnfc_host.sv
// Host controller that reads and programs a parallel NOR flash over its pins.
//
// Contract
// - Program starts only via command write cycles.
// - Bypass mode programs in two cycles, otherwise four.
// - Completion shown by polling bit, toggle bit and busy output.
`timescale 1ns/10ps
module pnfc_host (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              req_valid,
   input  wire pnfc_pkg::pnfc_req_t req,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [15:0]            rsp_data,
   output logic                   rsp_err,
   output pnfc_pkg::pnfc_bus_t    bus,
   output logic                   flash_rst_n,
   output logic                   byte_n,
   output logic                   protect_accel_pin,
   input  wire logic [15:0]       dq_in,
   input  wire logic              busy_indicator
);
   import pnfc_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_READ  = 3'b001,
      ST_WRITE = 3'b011,
      ST_GAP   = 3'b010,
      ST_POLL  = 3'b110,
      ST_RST   = 3'b111
   } pnfc_state_t;

   pnfc_state_t         state_q, state_d;
   pnfc_req_t           req_q;
   pnfc_bus_t           bus_q;
   logic [3:0]          cnt_q;
   logic [1:0]          step_q;
   logic [1:0]          nsteps_q;
   logic [ADDR_W-4:0]   page_q;
   logic                page_ok_q;
   logic [15:0]         prev_q;
   logic                first_q;
   logic                rsp_valid_q, rsp_err_q, rdy_q, frst_q;
   logic                prev_busy_q, byte_q, wp_q;
   logic [15:0]         rsp_data_q;

   // Address and data of command write number n of a program sequence.
   function automatic logic [ADDR_W+DATA_W-1:0] seq_word(
      input logic [1:0] n, input logic byp, input pnfc_req_t r);
      if (byp) begin
         seq_word = (n == 2'd0) ? {UNLOCK_A1, CMD_PROG} : {r.addr, r.data};
      end else begin
         unique case (n)
            2'd0: seq_word = {UNLOCK_A1, UNLOCK_D1};
            2'd1: seq_word = {UNLOCK_A2, UNLOCK_D2};
            2'd2: seq_word = {UNLOCK_A1, CMD_PROG};
            2'd3: seq_word = {r.addr, r.data};
         endcase
      end
   endfunction : seq_word

   wire               cnt_done  = (cnt_q == 4'h1);
   wire               same_page = page_ok_q
                                 && (req.addr[ADDR_W-1:3] == page_q);
   wire [ADDR_W+DATA_W-1:0] cur_word = seq_word(step_q, req_q.bypass, req_q);
   wire               last_step = (step_q == nsteps_q);
   // Polling bit equals the written data bit and toggle bit holds still.
   wire               poll_done = !busy_indicator && !first_q
      && (dq_in[POLL_BIT] == req_q.data[POLL_BIT])
      && (dq_in[TOGGLE_BIT] == prev_q[TOGGLE_BIT]);
   // A zero cannot be programmed back to one, so two status reads taken
   // with busy low that still do not settle end the program as failed.
   wire               prog_fail = (state_q == ST_POLL) && cnt_done
      && !busy_indicator && !first_q && !prev_busy_q && !poll_done;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:  if (req_valid && rdy_q) begin
            unique case (req.op)
               PNFC_OP_READ:  state_d = ST_READ;
               PNFC_OP_PROG:  state_d = ST_WRITE;
               PNFC_OP_ABORT: state_d = ST_RST;
               default:       state_d = ST_IDLE;
            endcase
         end
         ST_READ:  if (cnt_done) state_d = ST_IDLE;
         ST_WRITE: if (cnt_done) state_d = ST_GAP;
         ST_GAP:   state_d = last_step ? ST_POLL : ST_WRITE;
         ST_POLL:  if (cnt_done && (poll_done || prog_fail))
                      state_d = ST_IDLE;
         ST_RST:   if (cnt_done) state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q     <= ST_IDLE;
         req_q       <= '0;
         bus_q       <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
         cnt_q       <= 4'h0;
         step_q      <= 2'd0;
         nsteps_q    <= 2'd0;
         page_q      <= '0;
         page_ok_q   <= 1'b0;
         prev_q      <= 16'hFFFF;
         first_q     <= 1'b1;
         rsp_valid_q <= 1'b0;
         rsp_err_q   <= 1'b0;
         rsp_data_q  <= 16'h0000;
         rdy_q       <= 1'b0;
         frst_q      <= 1'b0;
         prev_busy_q <= 1'b1;
         byte_q      <= 1'b1;
         wp_q        <= 1'b0;
      end else begin
         state_q     <= state_d;
         rsp_valid_q <= 1'b0;
         // Ready follows a whole idle cycle, so it never meets an answer.
         rdy_q       <= (state_d == ST_IDLE) && (state_q == ST_IDLE);
         frst_q      <= 1'b1;
         byte_q      <= 1'b1;
         // Write-protect held low keeps the edge sector guarded.
         wp_q        <= 1'b0;
         if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
         unique case (state_q)
            ST_IDLE: begin
               // Chip deselected while idle so the flash drops to standby.
               bus_q.ce_n <= 1'b1;
               bus_q.oe_n <= 1'b1;
               bus_q.we_n <= 1'b1;
               bus_q.dq_oe <= 1'b0;
               if (req_valid && rdy_q) begin
                  req_q <= req;
                  if (req.op == PNFC_OP_READ) begin
                     bus_q <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1,
                                dq_oe: 1'b0, addr: req.addr, dq: '0};
                     cnt_q <= same_page ? CNT_PAGE : CNT_ACC;
                     page_q <= req.addr[ADDR_W-1:3];
                  end else if (req.op == PNFC_OP_PROG) begin
                     step_q   <= 2'd0;
                     nsteps_q <= req.bypass ? 2'd1 : 2'd3;
                     cnt_q    <= CNT_WR;
                     page_ok_q <= 1'b0;
                  end else if (req.op == PNFC_OP_ABORT) begin
                     cnt_q    <= CNT_ACC;
                     frst_q   <= 1'b0;
                     page_ok_q <= 1'b0;
                  end
               end
            end
            ST_READ: if (cnt_done) begin
               rsp_valid_q <= 1'b1;
               rsp_err_q   <= 1'b0;
               rsp_data_q  <= dq_in;
               page_ok_q   <= 1'b1;
            end
            ST_WRITE: begin
               // A program without bypass starts with an unlock sequence of writes; bypass skips it.
               bus_q.ce_n  <= 1'b0;
               bus_q.we_n  <= cnt_done;
               bus_q.oe_n  <= 1'b1;
               bus_q.dq_oe <= 1'b1;
               bus_q.addr  <= cur_word[ADDR_W+DATA_W-1:DATA_W];
               bus_q.dq    <= cur_word[DATA_W-1:0];
            end
            ST_GAP: begin
               bus_q.ce_n  <= 1'b1;
               bus_q.we_n  <= 1'b1;
               bus_q.dq_oe <= 1'b0;
               step_q      <= step_q + 2'd1;
               cnt_q       <= last_step ? CNT_ACC : CNT_WR;
               first_q     <= 1'b1;
               prev_busy_q <= 1'b1;
            end
            ST_POLL: begin
               // Status reads repeat until busy clears and polling settles, or a second busy-low read still does not settle.
               bus_q.ce_n <= 1'b0;
               bus_q.oe_n <= cnt_done;
               bus_q.addr <= req_q.addr;
               if (cnt_done) begin
                  prev_q  <= dq_in;
                  first_q <= 1'b0;
                  prev_busy_q <= busy_indicator;
                  cnt_q   <= CNT_ACC;
                  if (poll_done || prog_fail) begin
                     rsp_valid_q <= 1'b1;
                     rsp_err_q   <= prog_fail;
                     rsp_data_q  <= dq_in;
                  end
               end
            end
            ST_RST: begin
               frst_q <= cnt_done;
               if (cnt_done) rsp_valid_q <= 1'b1;
               if (cnt_done) rsp_err_q   <= 1'b0;
            end
         endcase
      end
   end

   assign req_ready         = rdy_q;
   assign rsp_valid         = rsp_valid_q;
   assign rsp_data          = rsp_data_q;
   assign rsp_err           = rsp_err_q;
   assign bus               = bus_q;
   assign flash_rst_n       = frst_q;
   assign byte_n            = byte_q;
   assign protect_accel_pin = wp_q;
endmodule : pnfc_host

// file: test/pnfc_host_checker.sv
// Checker of the host controller's port behaviour.
`timescale 1ns/10ps
module pnfc_host_checker
   import pnfc_pkg::*;
(
   input wire logic      clk,
   input wire logic      nrst,
   input wire logic      req_valid,
   input wire pnfc_req_t req,
   input wire logic      req_ready,
   input wire logic      rsp_valid,
   input wire logic      rsp_err,
   input wire pnfc_bus_t bus,
   input wire logic      flash_rst_n,
   input wire logic      byte_n,
   input wire logic      protect_accel_pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire take = req_valid && req_ready;
   // Mirror of the open page, so page hits can be told from full accesses.
   logic [ADDR_W-4:0] pg_q;
   logic              pg_ok_q;
   wire               hit = pg_ok_q && (req.addr[ADDR_W-1:3] == pg_q);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pg_q    <= '0;
         pg_ok_q <= 1'b0;
      end else if (take) begin
         pg_ok_q <= (req.op == PNFC_OP_READ);
         pg_q    <= req.addr[ADDR_W-1:3];
      end
   end
   sequence s_rst_pulse; !flash_rst_n [*3]; endsequence
   sequence s_answer; rsp_valid ##1 !rsp_valid; endsequence
   property p_rd_lat;
      take && req.op == PNFC_OP_READ && !hit |->
         ##1 !rsp_valid [*3] ##1 rsp_valid;
   endproperty
   property p_rd_page;
      take && req.op == PNFC_OP_READ && hit |-> ##1 !rsp_valid ##1 rsp_valid;
   endproperty
   property p_abort;
      take && req.op == PNFC_OP_ABORT |=> s_rst_pulse ##1 s_answer;
   endproperty
   property p_pulse; rsp_valid |-> !req_ready ##1 !rsp_valid; endproperty
   property p_take; take |=> !req_ready; endproperty
   property p_we; !bus.we_n |-> !bus.ce_n && bus.dq_oe && bus.oe_n; endproperty
   property p_we_w; $fell(bus.we_n) |-> !bus.we_n ##1 bus.we_n; endproperty
   property p_rd_oe; !bus.oe_n |-> !bus.dq_oe && !bus.ce_n; endproperty
   property p_err; $rose(rsp_err) |-> rsp_valid; endproperty
   property p_pins; byte_n && !protect_accel_pin; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read latency wrong");
   a_rd_page: assert property (p_rd_page) else $error("page read slow");
   a_abort: assert property (p_abort) else $error("abort pulse wrong");
   a_pulse: assert property (p_pulse) else $error("answer not a pulse");
   a_take: assert property (p_take) else $error("ready after take");
   a_we: assert property (p_we) else $error("write strobe alone");
   a_we_w: assert property (p_we_w) else $error("write width wrong");
   a_rd_oe: assert property (p_rd_oe) else $error("read contention");
   a_err: assert property (p_err) else $error("error without answer");
   a_pins: assert property (p_pins) else $error("mode pins wrong");
endmodule : pnfc_host_checker

bind pnfc_host pnfc_host_checker chk (.clk(clk), .nrst(nrst),
   .req_valid(req_valid), .req(req), .req_ready(req_ready),
   .rsp_valid(rsp_valid), .rsp_err(rsp_err), .bus(bus),
   .flash_rst_n(flash_rst_n), .byte_n(byte_n),
   .protect_accel_pin(protect_accel_pin));

// file: test/pnfc_flash_model.sv
// Behavioural model of the flash device on the far side of the host.
`timescale 1ns/10ps
module pnfc_flash_model
   import pnfc_pkg::*;
#(parameter int BUSY_CYC = 8)
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire pnfc_bus_t bus,
   output logic [15:0]    dq_in,
   output logic           busy_indicator
);
   logic [15:0] mem_q [64];
   logic [15:0] pend_q;
   logic [1:0]  seq_q = 2'h0;
   logic        we_q = 1'b1;
   logic        oe_q = 1'b1;
   logic        tgl_q = 1'b0;
   logic [15:0] last_q = 16'hFFFF;
   int          busy_q = 0;
   wire         commit = !we_q && bus.we_n;
   wire         rd     = !bus.ce_n && !bus.oe_n;
   wire [5:0]   a      = bus.addr[5:0];
   wire [15:0]  stat   = {8'h00, ~pend_q[7], tgl_q, 6'h00};
   // Reads answer within the cycle, as the page buffer beats one clock;
   // a released bus shows the inverse so stale data never matches.
   assign dq_in = !rd ? ~last_q : (busy_q != 0) ? stat : mem_q[a];
   assign busy_indicator = busy_q != 0;
   initial begin
      for (int i = 0; i < 64; i++) mem_q[i] = 16'hFFFF;
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_q  <= 2'h0;
         busy_q <= 0;
         we_q   <= 1'b1;
      end else begin
         we_q <= bus.we_n;
         oe_q <= bus.oe_n;
         if (busy_q > 0) busy_q <= busy_q - 1;
         if (!bus.oe_n && oe_q) tgl_q <= ~tgl_q;
         if (commit && busy_q == 0) begin
            seq_q <= 2'h0;
            if (seq_q == 2'h3) begin
               mem_q[a] <= mem_q[a] & bus.dq;
               pend_q   <= bus.dq;
               busy_q   <= BUSY_CYC;
            end else if (seq_q == 2'h0 && bus.addr == UNLOCK_A1
                         && bus.dq == UNLOCK_D1) seq_q <= 2'h1;
            else if (seq_q == 2'h1 && bus.addr == UNLOCK_A2
                     && bus.dq == UNLOCK_D2) seq_q <= 2'h2;
            else if (seq_q != 2'h1 && bus.dq == CMD_PROG) seq_q <= 2'h3;
         end
         if (rd) last_q <= dq_in;
      end
   end
endmodule : pnfc_flash_model

// file: test/test_parallel_nor_flash_command_core.sv
// Testbench for the parallel flash host controller.
`timescale 1ns/10ps
module test_parallel_nor_flash_command_core;
   import pnfc_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, req_valid = 1'b0;
   pnfc_req_t   req = '0;
   logic        req_ready, rsp_valid, rsp_err, flash_rst_n, byte_n;
   logic        protect_accel_pin, busy_indicator;
   logic [15:0] rsp_data, dq_in;
   pnfc_bus_t   bus;
   int          error_cnt = 0, samples_checked = 0, cyc = 0, lat, wr_cnt;
   always #20 clk = ~clk;
   pnfc_host uut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_err(rsp_err), .bus(bus), .flash_rst_n(flash_rst_n),
      .byte_n(byte_n), .protect_accel_pin(protect_accel_pin),
      .dq_in(dq_in), .busy_indicator(busy_indicator));
   pnfc_flash_model dev (.clk(clk), .rst_n(flash_rst_n), .bus(bus),
      .dq_in(dq_in), .busy_indicator(busy_indicator));
   always @(negedge bus.we_n) wr_cnt++;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic conclude();
      if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Caller is always just after a rising edge.
   task automatic xfer(input pnfc_op_t op, input logic byp,
                       input logic [21:0] a, input logic [15:0] d);
      lat = 0;
      while (req_ready !== 1'b1 && lat < 50) begin
         @(posedge clk);
         #2;
         lat++;
      end
      check({15'h0000, req_ready}, 16'h0001);
      req_valid = 1'b1;
      req = '{op: op, bypass: byp, addr: a, data: d};
      @(posedge clk);
      #2;
      req_valid = 1'b0;
      lat = 0;
      while (rsp_valid !== 1'b1 && lat < 200) begin
         @(posedge clk);
         #2;
         lat++;
      end
      check({15'h0000, rsp_valid}, 16'h0001);
   endtask : xfer
   task automatic t_read_page();
      xfer(PNFC_OP_READ, 1'b0, 22'h000010, 16'h0000);
      check(rsp_data, 16'hFFFF);
      check(16'(lat), 16'(ACC_CYC));
      xfer(PNFC_OP_READ, 1'b0, 22'h000011, 16'h0000);
      check(16'(lat), 16'(PAGE_CYC));
      check(rsp_data, 16'hFFFF);
      xfer(PNFC_OP_READ, 1'b0, 22'h000018, 16'h0000);
      check(16'(lat), 16'(ACC_CYC));
   endtask : t_read_page
   task automatic t_prog(input logic byp, input logic [15:0] d,
                         input logic [15:0] n, input logic [15:0] exp,
                         input logic err);
      wr_cnt = 0;
      xfer(PNFC_OP_PROG, byp, 22'h000020, d);
      check(16'(wr_cnt), n);
      check({15'h0000, rsp_err}, {15'h0000, err});
      check({15'h0000, rsp_data[7]}, {15'h0000, exp[7]});
      xfer(PNFC_OP_READ, 1'b0, 22'h000020, 16'h0000);
      check(rsp_data, exp);
   endtask : t_prog
   task automatic t_abort();
      xfer(PNFC_OP_ABORT, 1'b0, 22'h000000, 16'h0000);
      check(16'(lat), 16'(ACC_CYC));
      check({15'h0000, rsp_err}, 16'h0000);
      xfer(PNFC_OP_READ, 1'b0, 22'h000020, 16'h0000);
      check(rsp_data, 16'h0000);
      xfer(PNFC_OP_READ, 1'b0, 22'h000010, 16'h0000);
      check(rsp_data, 16'hFFFF);
   endtask : t_abort
   initial begin
      repeat (12) @(posedge clk);
      #2;
      nrst = 1'b1;
      @(posedge clk);
      #2;
      t_read_page();
      t_prog(1'b0, 16'hF0F0, 16'h0004, 16'hF0F0, 1'b0);
      t_prog(1'b1, 16'h0FF0, 16'h0002, 16'h00F0, 1'b0);
      t_prog(1'b0, 16'hFF0F, 16'h0004, 16'h0000, 1'b0);
      t_prog(1'b1, 16'hFFFF, 16'h0002, 16'h0000, 1'b1);
      t_abort();
      conclude();
   end
endmodule : test_parallel_nor_flash_command_core
